// ===== hw/pcics_core.sv
// Purpose: target and initiator state machines, command/status registers
// Assumes: every pin sampled on clk, the single buffered PCI clock
// Notes:   address indication and FIFO flags are the only gated outputs
`timescale 1ns/1ps
`include "pcics_regs.svh"

// ************************************
// Write data buffer
// ************************************
module pcics_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic [W-1:0]   in_data,
   input  wire logic           in_valid,
   output logic                in_ready,
   output logic [W-1:0]        out_data,
   output logic                out_valid,
   input  wire logic           out_ready,
   output logic [$clog2(D):0]  level
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;
   assign in_ready  = cnt_q != DEPTH_C;
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   // Pointers wrap naturally, so depth must be a power of two
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem_q[wr_q] <= in_data;
   end
endmodule : pcics_fifo

// Functional notes
// - Initiator enters data state the clock after address indication asserted.
// - On grant without request, flag parking and drive AD, C/BE, PAR.
// - Address indication combinational: grant, idle bus and request all present.
// - Address indication overlaps idle or parking indication by one cycle.
// - Address phase drives start address from shared bus and user command.
// - Master disabled: idle without grant, parking with grant; target-only always idle.
// - Target idle without activity; busy while decoding or not addressed.
// - Target enters data state on range match or configuration access.
// - After user termination and STOP, target waits in back-off until done.
// - Command bits registered or zero for unsupported features.
// - No bus access or REQ unless bus master enable set.
// - Memory and I/O commands ignored unless their enable bits set.
// - Status bits set by hardware, cleared by writing one.
// - Device-select timing field reads binary 10, slow decode.
// - Fast back-to-back and 66 MHz capable bits read zero.
// - Status half is registered bits or constants only.
// - Transaction bits follow any bus activity; aborts only when involved.
// - Lower six transaction bits pulse the cycle after the condition.
// - Eight separate transaction-status indications are provided.
// - Every flip-flop runs on the single PCI clock.
// - Initiator disabled at power-on and bus reset until enabled.
// - User terminate asserts STOP; ready selects retry or disconnect.
module pcics_core
   import pcics_pkg::*;
#(
   parameter bit INITIATOR_EN = 1'b1
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           frame_n_in,
   input  wire logic           irdy_n_in,
   input  wire logic           trdy_n_in,
   input  wire logic           stop_n_in,
   input  wire logic           devsel_n_in,
   input  wire logic           gnt_n_in,
   input  wire logic [31:0]    ad_in,
   output logic                frame_n_out,
   output logic                frame_oe,
   output logic                irdy_n_out,
   output logic                irdy_oe,
   output logic                trdy_n_out,
   output logic                trdy_oe,
   output logic                stop_n_out,
   output logic                stop_oe,
   output logic                devsel_n_out,
   output logic                devsel_oe,
   output logic [31:0]         ad_out,
   output logic                ad_oe,
   output logic [3:0]          cbe_out,
   output logic                cbe_oe,
   output logic                par_out,
   output logic                par_oe,
   output logic                req_n_out,
   input  wire logic           mem_hit,
   input  wire logic           io_hit,
   input  wire logic           cfg_hit,
   input  wire logic           decode_done,
   input  wire logic           tgt_write,
   input  wire logic           user_term,
   input  wire logic           user_ready,
   input  wire logic           user_abort,
   input  wire logic           user_request,
   input  wire logic           user_complete,
   input  wire logic           user_wrdn,
   input  wire logic [31:0]    internal_shared_bus,
   input  wire logic [3:0]     user_cmd_byte_enables,
   input  wire logic           cfg_wr,
   input  wire logic [3:0]     cfg_be,
   input  wire logic [31:0]    cfg_wdata,
   input  wire logic           parity_err,
   input  wire logic           data_parity_err,
   input  wire logic           serr_signaled,
   output logic [31:0]         tgt_wr_data,
   output logic                tgt_wr_valid,
   input  wire logic           tgt_wr_ready,
   output logic                tgt_idle,
   output logic                tgt_bus_busy,
   output logic                tgt_data,
   output logic                target_terminating_wait,
   output logic                ini_idle,
   output logic                bus_park_drive,
   output logic                ini_addr_n,
   output logic                ini_data,
   output logic [39:0]         extended_cmd_status
);
   import pcics_pkg::*;
   // ************************************
   // State and registers
   // ************************************
   pcics_tgt_e  tst_q, tst_d;
   pcics_ini_e  ist_q, ist_d;
   pcics_reg_t  cmd_q, cmd_d;
   pcics_reg_t  st_q, st_d;
   pcics_reg_t  st_set, st_clr;
   pcics_xs_t   xs_d;
   logic [2:0]  ma_cnt_q;
   logic        addr_ph_q;
   logic        abort_q;
   logic [39:0] csr_q;
   logic [2:0]  fifo_level;
   logic        fifo_in_ready;
   logic        frame_n_q, frame_oe_q, irdy_n_q, irdy_oe_q;
   logic        trdy_n_q, trdy_oe_q, stop_n_q, stop_oe_q;
   logic        devsel_n_q, devsel_oe_q, req_n_q;
   logic [31:0] ad_q;
   logic [3:0]  cbe_q;
   logic        ad_oe_q, cbe_oe_q, par_q, par_oe_q;
   logic        t_idle_q, t_busy_q, t_data_q, t_back_q;
   logic        i_idle_q, i_park_q, i_data_q;

   // ************************************
   // Decode
   // ************************************
   wire gnt       = ~gnt_n_in;
   wire bus_idle  = frame_n_in & irdy_n_in;
   wire mst_ok    = INITIATOR_EN & cmd_q[`PCICS_CMD_MST];
   wire own       = ist_q == INI_DATA;
   wire hit       = (mem_hit & cmd_q[`PCICS_CMD_MEM])
                  | (io_hit & cmd_q[`PCICS_CMD_IO]) | cfg_hit;
   wire claim     = decode_done & hit & ~own;
   wire t_active  = tst_q == TGT_DATA;
   wire t_engaged = t_active | (tst_q == TGT_TARGET_TERMINATING_WAIT);
   wire i_datap   = own & ~addr_ph_q;
   wire ma_hit    = i_datap & devsel_n_in & (ma_cnt_q == `PCICS_MA_LIMIT);
   wire rx_tabort = i_datap & ~stop_n_in & devsel_n_in;
   wire mst_end   = i_datap & ((frame_n_q & ~irdy_n_q & (~trdy_n_in | ~stop_n_in))
                  | ma_hit | rx_tabort);
   wire room      = fifo_level <= `PCICS_FIFO_ROOM;
   wire push      = t_engaged & tgt_write & ~irdy_n_in & ~trdy_n_in & trdy_oe_q
                  & fifo_in_ready;
   wire park_ok   = INITIATOR_EN & gnt & bus_idle;
   // Combinational on purpose: user drivers must open in this very cycle
   assign ini_addr_n = ~(mst_ok & gnt & bus_idle & user_request & ~own);
   wire t_dat_d   = tst_d == TGT_DATA;
   wire t_eng_d   = t_dat_d | (tst_d == TGT_TARGET_TERMINATING_WAIT);
   wire i_dat_d   = ist_d == INI_DATA;
   wire i_park_d  = ist_d == INI_PARK;
   wire abort_d   = (abort_q | (t_active & user_abort)) & t_eng_d;
   wire wbyte_lo  = cfg_wr & cfg_be[0];
   wire wbyte_hi  = cfg_wr & cfg_be[1];

   // ************************************
   // Initiator next state
   // ************************************
   always_comb begin
      ist_d = ist_q;
      case (ist_q)
         INI_IDLE, INI_PARK: begin
            if (!ini_addr_n) ist_d = INI_DATA;
            else if (park_ok) ist_d = INI_PARK;
            else ist_d = INI_IDLE;
         end
         INI_DATA: begin
            if (mst_end) ist_d = park_ok ? INI_PARK : INI_IDLE;
         end
         default: ist_d = INI_IDLE;
      endcase
   end

   // ************************************
   // Target next state
   // ************************************
   always_comb begin
      tst_d = tst_q;
      case (tst_q)
         TGT_IDLE: begin
            if (!frame_n_in) tst_d = claim ? TGT_DATA : TGT_BUSY;
         end
         TGT_BUSY: begin
            if (claim) tst_d = TGT_DATA;
            else if (bus_idle) tst_d = TGT_IDLE;
         end
         TGT_DATA: begin
            if ((user_term | user_abort) & ~stop_n_in) tst_d = TGT_TARGET_TERMINATING_WAIT;
            else if (bus_idle | (frame_n_in & ~irdy_n_in & ~trdy_n_in)) tst_d = TGT_IDLE;
         end
         TGT_TARGET_TERMINATING_WAIT: begin
            if (bus_idle) tst_d = TGT_IDLE;
         end
         default: tst_d = TGT_IDLE;
      endcase
   end

   // ************************************
   // Command and status registers
   // ************************************
   always_comb begin
      cmd_d = cmd_q;
      if (wbyte_lo) cmd_d[7:0] = cfg_wdata[7:0];
      if (wbyte_hi) cmd_d[15:8] = cfg_wdata[15:8];
      cmd_d = cmd_d & `PCICS_CMD_RW_MASK;
      st_set = '0;
      st_set[`PCICS_ST_DPERR] = data_parity_err & cmd_q[`PCICS_CMD_PERR] & own;
      st_set[`PCICS_ST_SIGTA] = t_active & user_abort;
      st_set[`PCICS_ST_RXTA]  = rx_tabort;
      st_set[`PCICS_ST_RXMA]  = ma_hit;
      st_set[`PCICS_ST_SIGSE] = serr_signaled & cmd_q[`PCICS_CMD_SERR];
      st_set[`PCICS_ST_DETPE] = parity_err;
      st_clr = {{8{cfg_wr & cfg_be[3]}}, {8{cfg_wr & cfg_be[2]}}} & cfg_wdata[31:16];
      // Set wins over a clear in the same cycle
      st_d = ((st_q & ~st_clr) | st_set) & `PCICS_ST_W1C_MASK;
   end

   // ************************************
   // Transaction status
   // ************************************
   always_comb begin
      xs_d = '0;
      xs_d[`PCICS_XS_VALID]  = ~irdy_n_in & ~trdy_n_in;
      xs_d[`PCICS_XS_END]    = frame_n_in & ~irdy_n_in & (~trdy_n_in | ~stop_n_in);
      xs_d[`PCICS_XS_NORMAL] = frame_n_in & ~irdy_n_in & ~trdy_n_in & stop_n_in;
      xs_d[`PCICS_XS_TTERM]  = ~irdy_n_in & ~stop_n_in;
      xs_d[`PCICS_XS_NODATA] = ~irdy_n_in & ~stop_n_in & trdy_n_in & ~devsel_n_in;
      xs_d[`PCICS_XS_WDATA]  = ~irdy_n_in & ~stop_n_in & ~trdy_n_in;
      xs_d[`PCICS_XS_TABORT] = (t_engaged | own) & ~stop_n_in & devsel_n_in;
      xs_d[`PCICS_XS_MABORT] = ma_hit;
   end

   // ************************************
   // Clocked state, all on the PCI clock
   // ************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ist_q     <= INI_IDLE;
         tst_q     <= TGT_IDLE;
         cmd_q     <= '0;
         st_q      <= '0;
         csr_q     <= {8'h00, `PCICS_ST_RO_VAL, 16'h0000};
         ma_cnt_q  <= '0;
         addr_ph_q <= 1'b0;
         abort_q   <= 1'b0;
      end else begin
         ist_q     <= ist_d;
         tst_q     <= tst_d;
         cmd_q     <= cmd_d;
         st_q      <= st_d;
         csr_q     <= {xs_d, st_d | `PCICS_ST_RO_VAL, cmd_d};
         ma_cnt_q  <= (i_datap & devsel_n_in) ? ma_cnt_q + 3'h1 : 3'h0;
         addr_ph_q <= i_dat_d & ~own;
         abort_q   <= abort_d;
      end
   end

   // ************************************
   // Bus drive
   // ************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_n_q <= 1'b1;
         frame_oe_q <= 1'b0;
         irdy_n_q <= 1'b1;
         irdy_oe_q <= 1'b0;
         req_n_q <= 1'b1;
         ad_q <= '0;
         cbe_q <= '0;
         ad_oe_q <= 1'b0;
         cbe_oe_q <= 1'b0;
         par_q <= 1'b0;
         par_oe_q <= 1'b0;
      end else begin
         frame_n_q <= ~i_dat_d | (i_datap & (frame_n_q | user_complete | ~stop_n_in));
         frame_oe_q <= i_dat_d;
         irdy_n_q <= ~(i_dat_d & own);
         irdy_oe_q <= i_dat_d;
         req_n_q <= ~(mst_ok & user_request & ~own);
         // Parked values are arbitrary; zero keeps the lines from floating
         ad_q <= i_park_d ? 32'h00000000 : internal_shared_bus;
         cbe_q <= i_park_d ? 4'h0 : user_cmd_byte_enables;
         ad_oe_q <= i_park_d | (i_dat_d & (~own | user_wrdn))
                  | (t_dat_d & ~tgt_write);
         cbe_oe_q <= i_park_d | i_dat_d;
         par_q <= ^{ad_q, cbe_q};
         par_oe_q <= ad_oe_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trdy_n_q <= 1'b1;
         trdy_oe_q <= 1'b0;
         stop_n_q <= 1'b1;
         stop_oe_q <= 1'b0;
         devsel_n_q <= 1'b1;
         devsel_oe_q <= 1'b0;
      end else begin
         // Buffer holding more than two words withholds TRDY, stalling the bus master
         trdy_n_q <= ~(t_dat_d & user_ready & ~abort_d & (~tgt_write | room));
         trdy_oe_q <= t_eng_d;
         stop_n_q <= ~((t_dat_d & (user_term | user_abort))
                   | (tst_d == TGT_TARGET_TERMINATING_WAIT));
         stop_oe_q <= t_eng_d;
         devsel_n_q <= ~(t_eng_d & ~abort_d);
         devsel_oe_q <= t_eng_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         t_idle_q <= 1'b1;
         t_busy_q <= 1'b0;
         t_data_q <= 1'b0;
         t_back_q <= 1'b0;
         i_idle_q <= 1'b1;
         i_park_q <= 1'b0;
         i_data_q <= 1'b0;
      end else begin
         t_idle_q <= tst_d == TGT_IDLE;
         t_busy_q <= tst_d == TGT_BUSY;
         t_data_q <= t_dat_d;
         t_back_q <= tst_d == TGT_TARGET_TERMINATING_WAIT;
         i_idle_q <= ist_d == INI_IDLE;
         i_park_q <= i_park_d;
         i_data_q <= i_dat_d;
      end
   end

   pcics_fifo #(.W(32), .D(4)) u_wbuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (ad_in),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (tgt_wr_data),
      .out_valid (tgt_wr_valid),
      .out_ready (tgt_wr_ready),
      .level     (fifo_level)
   );

   assign frame_n_out = frame_n_q;
   assign frame_oe = frame_oe_q;
   assign irdy_n_out = irdy_n_q;
   assign irdy_oe = irdy_oe_q;
   assign trdy_n_out = trdy_n_q;
   assign trdy_oe = trdy_oe_q;
   assign stop_n_out = stop_n_q;
   assign stop_oe = stop_oe_q;
   assign devsel_n_out = devsel_n_q;
   assign devsel_oe = devsel_oe_q;
   assign ad_out = ad_q;
   assign ad_oe = ad_oe_q;
   assign cbe_out = cbe_q;
   assign cbe_oe = cbe_oe_q;
   assign par_out = par_q;
   assign par_oe = par_oe_q;
   assign req_n_out = req_n_q;
   assign tgt_idle = t_idle_q;
   assign tgt_bus_busy = t_busy_q;
   assign tgt_data = t_data_q;
   assign target_terminating_wait = t_back_q;
   assign ini_idle = i_idle_q;
   assign bus_park_drive = i_park_q;
   assign ini_data = i_data_q;
   assign extended_cmd_status = csr_q;

   // ************************************
   // Checks
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_addr;
      !ini_addr_n;
   endsequence
   sequence s_term_seen;
      t_data_q && user_term && !stop_n_in && !bus_idle;
   endsequence

   a_ini_data_follow: assert property (s_addr |=> i_data_q ##0 !frame_n_q)
      else $error("initiator missed data state");
   a_park_drives: assert property (i_park_q |-> ad_oe_q && cbe_oe_q ##1 par_oe_q)
      else $error("parked bus not driven");
   a_addr_cause: assert property (s_addr |-> !gnt_n_in && bus_idle && user_request)
      else $error("address indication without cause");
   a_addr_overlap: assert property (s_addr |-> i_idle_q || i_park_q)
      else $error("address indication overlaps no state");
   a_addr_drive: assert property (s_addr |=> ad_oe_q && cbe_oe_q
      && ad_q == $past(internal_shared_bus) && cbe_q == $past(user_cmd_byte_enables))
      else $error("address phase drive wrong");
   a_mst_disabled: assert property (!cmd_q[`PCICS_CMD_MST] && !own |=> !i_data_q)
      else $error("initiator left idle while disabled");
   a_req_gate: assert property (!req_n_q |-> $past(cmd_q[`PCICS_CMD_MST]))
      else $error("request without master enable");
   a_tgt_busy: assert property (t_idle_q && !frame_n_in && !claim |=> t_busy_q)
      else $error("target not busy on foreign frame");
   a_tgt_claim: assert property (t_busy_q && claim |=> t_data_q ##0 !devsel_n_q)
      else $error("target did not claim");
   a_mem_ignore: assert property (t_busy_q && !io_hit && !cfg_hit
      && !cmd_q[`PCICS_CMD_MEM] |=> !t_data_q)
      else $error("memory access claimed while disabled");
   a_target_terminating_wait: assert property (s_term_seen |=> t_back_q [*1] ##0 !stop_n_q)
      else $error("no back-off after termination");
   a_stop_term: assert property (t_data_q && user_term |=>
      (!t_data_q && !t_back_q) || !stop_n_q)
      else $error("terminate did not assert stop");
   a_w1c_clear: assert property (cfg_wr && cfg_be[3] && cfg_wdata[31] && !parity_err
      |=> !csr_q[31])
      else $error("status bit not cleared");
   a_w1c_keep: assert property (csr_q[31] && !(cfg_wr && cfg_be[3] && cfg_wdata[31])
      |=> csr_q[31])
      else $error("status bit lost");
   a_ro_fields: assert property ((csr_q[15:0] & ~`PCICS_CMD_RW_MASK) == 16'h0000
      && csr_q[26:25] == 2'h2 && !csr_q[21] && !csr_q[23] && csr_q[20:16] == 5'h00)
      else $error("read-only field changed");
   a_xs_pulse: assert property (csr_q[32] == $past(!irdy_n_in && !trdy_n_in))
      else $error("valid data pulse wrong");
   a_ma_involved: assert property (csr_q[39] |-> $past(own))
      else $error("master abort without involvement");
   a_reset_idle: assert property ($rose(rst_n) |-> t_idle_q && i_idle_q
      && csr_q[15:0] == 16'h0000 && req_n_q)
      else $error("reset state wrong");
endmodule : pcics_core

// ===== hw/pcics_regs.svh
// Purpose: offsets, field positions and constants of the PCI core CSR
// Assumes: included by bare name
// Notes:   fields follow the 40-bit extended command/status vector
`ifndef PCICS_REGS_SVH
`define PCICS_REGS_SVH
// ************************************
// Command register fields
// ************************************
`define PCICS_CMD_IO       0
`define PCICS_CMD_MEM      1
`define PCICS_CMD_MST      2
`define PCICS_CMD_PERR     6
`define PCICS_CMD_SERR     8
`define PCICS_CMD_RW_MASK  16'h0147
// ************************************
// Status register fields
// ************************************
`define PCICS_ST_DPERR     8
`define PCICS_ST_SIGTA     11
`define PCICS_ST_RXTA      12
`define PCICS_ST_RXMA      13
`define PCICS_ST_SIGSE     14
`define PCICS_ST_DETPE     15
`define PCICS_ST_W1C_MASK  16'hF900
`define PCICS_ST_RO_VAL    16'h0400
// ************************************
// Extended vector layout
// ************************************
`define PCICS_CSR_ST_LSB   16
`define PCICS_CSR_XS_LSB   32
`define PCICS_XS_VALID     0
`define PCICS_XS_END       1
`define PCICS_XS_NORMAL    2
`define PCICS_XS_TTERM     3
`define PCICS_XS_NODATA    4
`define PCICS_XS_WDATA     5
`define PCICS_XS_TABORT    6
`define PCICS_XS_MABORT    7
// ************************************
// Timing and buffering
// ************************************
`define PCICS_MA_LIMIT     3'h5
`define PCICS_FIFO_ROOM    3'h2
`endif

// ===== hw/pcics_pkg.sv
// Purpose: types shared by the PCI core state and CSR logic
// Assumes: nothing
// Notes:   state encodings left to the tools
package pcics_pkg;
   typedef enum logic [1:0] {TGT_IDLE, TGT_BUSY, TGT_DATA, TGT_TARGET_TERMINATING_WAIT} pcics_tgt_e;
   typedef enum logic [1:0] {INI_IDLE, INI_PARK, INI_DATA} pcics_ini_e;
   typedef logic [15:0] pcics_reg_t;
   typedef logic [7:0]  pcics_xs_t;
endpackage : pcics_pkg

// ===== test/pcics_agent.sv
// Purpose: far-side bus initiator issuing one short transaction
// Assumes: FRAME# and IRDY# pulled up when released
// Notes:   start held keeps the data phase open
`timescale 1ns/1ps
module pcics_agent (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic slow,
   input  wire logic trdy_n,
   input  wire logic stop_n,
   input  wire logic devsel_n,
   output logic      frame_n,
   output logic      irdy_n
);
   logic [1:0] ph_q;
   logic [1:0] ph_d;
   // Last phase ends on TRDY#, STOP# or no DEVSEL#, so no hang
   assign ph_d = (ph_q == 2'h0) ? {1'b0, start} : (ph_q == 2'h1) ? 2'h2 :
                 (ph_q == 2'h2) ? (start ? 2'h2 : 2'h3) :
                 ((!trdy_n || !stop_n || devsel_n) ? 2'h0 : 2'h3);
   assign frame_n = !(ph_q == 2'h1 || ph_q == 2'h2);
   assign irdy_n = !((ph_q == 2'h2 && !slow) || ph_q == 2'h3);
   always_ff @(posedge clk) begin
      ph_q <= rst_n ? ph_d : 2'h0;
   end
endmodule : pcics_agent

// ===== test/tb_top.sv
// Purpose: self-checking bench of the PCI state and CSR core
// Assumes: pull-ups on control lines, agent model on the far side
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
   import pcics_pkg::*;
   typedef struct {logic [3:0] be; logic [31:0] wd; logic [39:0] ex;} pcics_row_s;
   logic clk, rst_n, gnt_n_in, mem_hit, io_hit, cfg_hit, decode_done, tgt_write, user_term;
   logic user_ready, user_abort, user_request, user_complete, user_wrdn, cfg_wr, parity_err;
   logic data_parity_err, serr_signaled, tgt_wr_ready, start, slow, seen, a_frame_n, a_irdy_n;
   logic frame_n_out, frame_oe, irdy_n_out, irdy_oe, trdy_n_out, trdy_oe, stop_n_out, stop_oe;
   logic devsel_n_out, devsel_oe, ad_oe, cbe_oe, par_out, par_oe, req_n_out, tgt_wr_valid;
   logic tgt_idle, tgt_bus_busy, tgt_data, target_terminating_wait, ini_idle, bus_park_drive;
   logic ini_addr_n, ini_data;
   logic [3:0]  cfg_be, user_cmd_byte_enables, cbe_out;
   logic [31:0] cfg_wdata, ad_out, tgt_wr_data;
   logic [39:0] extended_cmd_status;
   int          err_total, num_checks, cyc, i;
   pcics_row_s  rows [4] = '{'{4'h3, 32'h0000_FFFF, 40'h00_0400_0147},
      '{4'hC, 32'hFFFF_FFFF, 40'h00_0400_0147}, '{4'h1, 32'h0, 40'h00_0400_0100},
      '{4'h3, 32'h0000_0006, 40'h00_0400_0006}};
   // Released AD shows inverted data, never a stale copy
   wire [31:0] ad_in = ad_oe ? ad_out : ~ad_out;
   wire frame_n_in = frame_oe ? frame_n_out : a_frame_n;
   wire irdy_n_in = irdy_oe ? irdy_n_out : a_irdy_n;
   wire trdy_n_in = !trdy_oe | trdy_n_out;
   wire stop_n_in = !stop_oe | stop_n_out;
   wire devsel_n_in = !devsel_oe | devsel_n_out;
   // NOR output acts as an active-low driver enable
   wire [31:0] internal_shared_bus = (bus_park_drive | ini_addr_n)
      ? 32'h1234_5678 : 32'h0000_0000;
   pcics_core dut_u (.*);
   pcics_agent agent_u (.clk, .rst_n, .start, .slow, .trdy_n(trdy_n_in), .stop_n(stop_n_in),
      .devsel_n(devsel_n_in), .frame_n(a_frame_n), .irdy_n(a_irdy_n));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t state bit %b not %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_csr(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t csr %h not %h", $time, got, exp);
      end
   endtask : chk_csr
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic cfg(input logic [3:0] be, input logic [31:0] wd);
      cfg_be = be;
      cfg_wdata = wd;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
   endtask : cfg
   initial begin
      {rst_n, mem_hit, io_hit, cfg_hit, decode_done, tgt_write, user_term, user_ready} = '0;
      {user_abort, user_request, user_complete, user_wrdn, cfg_wr, parity_err} = '0;
      {data_parity_err, serr_signaled, start, slow, gnt_n_in, tgt_wr_ready} = 6'h03;
      {cfg_be, cfg_wdata} = '0;
      user_cmd_byte_enables = 4'h7;
      tick(12);
      rst_n = 1'b1;
      chk_csr(extended_cmd_status, 40'h00_0400_0000);
      chk_bit(tgt_idle & ini_idle, 1'b1);
      foreach (rows[i]) begin
         cfg(rows[i].be, rows[i].wd);
         chk_csr(extended_cmd_status, rows[i].ex);
      end
      $display("register table done");
      {serr_signaled, parity_err} = 2'b11;
      tick(1);
      {serr_signaled, parity_err} = 2'b00;
      cfg(4'hC, 32'h0);
      chk_csr(extended_cmd_status, 40'h00_8400_0006);
      cfg(4'hC, 32'h8000_0000);
      chk_csr(extended_cmd_status, 40'h00_0400_0006);
      $display("status clear done");
      cfg(4'h3, 32'h4);
      {mem_hit, decode_done, start} = 3'b111;
      tick(3);
      chk_bit(tgt_bus_busy, 1'b1);
      {mem_hit, start} = 2'b00;
      for (i = 0; i < 9 && tgt_idle !== 1'b1; i++) tick(1);
      chk_bit(tgt_idle, 1'b1);
      cfg(4'h3, 32'h6);
      {cfg_hit, tgt_write, user_ready, slow, tgt_wr_ready, start} = 6'b111101;
      for (i = 0; i < 8 && tgt_data !== 1'b1; i++) tick(1);
      chk_bit(tgt_data, 1'b1);
      tick(2);
      chk_bit(tgt_wr_valid, 1'b0);
      slow = 1'b0;
      seen = 1'b0;
      for (i = 0; i < 8; i++) begin
         tick(1);
         seen |= extended_cmd_status[32];
      end
      chk_bit(seen & tgt_wr_valid & trdy_n_in, 1'b1);
      chk_bit(tgt_wr_data === 32'hEDCB_A987, 1'b1);
      {start, tgt_wr_ready} = 2'b01;
      for (i = 0; i < 9 && tgt_idle !== 1'b1; i++) tick(1);
      tick(6);
      chk_bit(tgt_wr_valid | (|extended_cmd_status[39:32]), 1'b0);
      $display("target write done");
      {user_ready, user_term, start} = 3'b011;
      for (i = 0; i < 8 && target_terminating_wait !== 1'b1; i++) tick(1);
      chk_bit(target_terminating_wait & !stop_n_in, 1'b1);
      start = 1'b0;
      for (i = 0; i < 9 && tgt_idle !== 1'b1; i++) tick(1);
      {user_term, user_abort, start} = 3'b011;
      for (i = 0; i < 8 && target_terminating_wait !== 1'b1; i++) tick(1);
      start = 1'b0;
      for (i = 0; i < 9 && tgt_idle !== 1'b1; i++) tick(1);
      chk_bit(extended_cmd_status[27], 1'b1);
      $display("target abort done");
      {user_abort, cfg_hit} = 2'b00;
      cfg(4'h3, 32'h2);
      {gnt_n_in, user_request} = 2'b01;
      tick(3);
      chk_bit(req_n_out & bus_park_drive & !ini_data, 1'b1);
      user_request = 1'b0;
      cfg(4'h3, 32'h6);
      chk_bit(bus_park_drive & ad_oe, 1'b1);
      user_request = 1'b1;
      #1;
      chk_bit(ini_addr_n, 1'b0);
      tick(1);
      chk_bit(ini_data, 1'b1);
      chk_bit(ad_oe && ad_out === 32'h1234_5678 && cbe_out === 4'h7, 1'b1);
      user_cmd_byte_enables = 4'h0;
      tick(1);
      {user_request, user_complete} = 2'b01;
      for (i = 0; i < 20 && ini_data !== 1'b0; i++) tick(1);
      chk_bit(extended_cmd_status[29], 1'b1);
      {gnt_n_in, user_complete} = 2'b10;
      tick(3);
      chk_bit(ini_idle, 1'b1);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      chk_csr(extended_cmd_status, 40'h00_0400_0000);
      $display("initiator and reset done");
      tally_and_finish();
   end
endmodule : tb_top
